// file: pprc_pkg.sv
package pprc_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_PORTS   = 6;  // Downstream port count
  localparam int NUM_ATTACH  = 4;  // Connector attach inputs
  localparam int ADDR_W      = 8;  // Register bus address width

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] OFF_PORT_EN  = 8'h00;  // Port enable control
  localparam logic [7:0] OFF_CONFIG   = 8'h04;  // Gang mode control
  localparam logic [7:0] OFF_STATE    = 8'h08;  // Live pin state
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;  // Sticky event status
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;  // Event mask

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CFG_GANG_BIT    = 0;   // Gang mode bit in config
  localparam int ST_OC_LSB       = 0;   // Overcurrent levels in state
  localparam int ST_ROLE_BIT     = 8;   // Arrangement bit in state
  localparam int ST_PHY_LSB      = 12;  // PHY enables in state
  localparam int IRQ_ROLE_BIT    = 8;   // Role change event bit

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [5:0] RST_PORT_EN  = 6'h00;  // All ports off
  localparam logic       RST_GANG     = 1'b0;   // Per-port power
  localparam logic [8:0] RST_IRQ_MASK = 9'h000; // All masked

  // ==========================================================================
  // AXI response codes
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address

  // ==========================================================================
  // Pin input synchroniser
  // ==========================================================================
  typedef enum logic [1:0] {
    PPRC_SYNC_IDLE = 2'b00,  // Stable level
    PPRC_SYNC_MOVE = 2'b01   // Agreed change seen
  } pprc_sync_st_t;

endpackage

// file: pprc_pin_sync.sv
`timescale 1ns/1ps
// ============================================================================
// Three-flop pin synchroniser with agreement filter
// ============================================================================
module pprc_pin_sync
  import pprc_pkg::*;
#(
  parameter int           W   = 1,
  parameter logic [W-1:0] INI = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Raw pins
  input  wire logic [W-1:0] pin,
  // Filtered levels
  output logic      [W-1:0] level
);

  logic [W-1:0] stage1;  // Metastability catcher
  logic [W-1:0] stage2;  // Second flop
  logic [W-1:0] stage3;  // Third flop

  // Shift chain; stage1 feeds only stage2
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= INI;
      stage2 <= INI;
      stage3 <= INI;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level moves once second and third agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level <= INI;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// file: pprc_top.sv
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Function
// - One power/sense pin per port, six
// - Enabled port, per-port mode: pin released, pull-up on
// - Enabled port, per-port mode: low pin means overcurrent
// - Disabled port: pin driven low
// - Gang mode: shared pin serves all
// - Swap low: port 0 up, 1 down
// - Swap high: port 0 down, 1 up
// - Indicator shows arrangement, 1 swapped
// - Attach high powers its PHY on
// - Attach low keeps its PHY off
module pprc_top
  import pprc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Per-port power/sense pins
  input  wire logic [NUM_PORTS-1:0]  port_power_sense_pin_in,
  output logic      [NUM_PORTS-1:0]  port_power_sense_pin_out,
  output logic      [NUM_PORTS-1:0]  port_power_sense_pin_oe,
  output logic      [NUM_PORTS-1:0]  port_power_sense_pin_pu,
  // Shared gang power/sense pin
  input  wire logic                  shared_power_sense_pin_in,
  output logic                       shared_power_sense_pin_out,
  output logic                       shared_power_sense_pin_oe,
  output logic                       shared_power_sense_pin_pu,
  // Host control of port enables
  input  wire logic [NUM_PORTS-1:0]  host_port_enable,
  // Role swap
  input  wire logic                  role_swap_request,
  output logic                       role_swap_indicator,
  output logic                       port0_is_upstream,
  output logic                       port1_is_upstream,
  // Connector attach and PHY power
  input  wire logic [NUM_ATTACH-1:0] connector_attach,
  output logic      [NUM_ATTACH-1:0] ss_phy_power_on,
  // Status to hub logic and interrupt
  output logic      [NUM_PORTS-1:0]  overcurrent_event,
  output logic                       irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [NUM_PORTS-1:0]  port_en_cfg;    // Software port enables
  logic                  gang_mode;      // Gang power configured
  logic [NUM_PORTS-1:0]  port_active;    // Enabled by config and host
  logic                  any_active;     // Gang supply wanted
  logic [NUM_PORTS-1:0]  port_pin_lvl;   // Synced per-port pins
  logic                  shared_pin_lvl; // Synced shared pin
  logic                  swap_lvl;       // Synced swap request
  logic [NUM_ATTACH-1:0] attach_lvl;     // Synced attach inputs
  logic [NUM_PORTS-1:0]  oc_now;         // Live overcurrent per port
  logic [8:0]            irq_stat;       // Sticky events
  logic [8:0]            irq_mask;       // Event enables
  logic [8:0]            irq_set;        // Events this cycle
  logic                  aw_held;        // Write address captured
  logic                  w_held;         // Write data captured
  logic [ADDR_W-1:0]     aw_addr;        // Captured write address
  logic [31:0]           w_data;         // Captured write data
  logic [3:0]            w_strb;         // Captured byte enables
  logic                  wr_fire;        // Perform write now
  logic [31:0]           next_rdata;     // Read mux value
  logic                  next_rok;       // Read address mapped

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Word offset decode, shared by read and write
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    hit = (a[ADDR_W-1:2] == off[7:2]);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Driven pins read as idle high, so release gives no false fault
  pprc_pin_sync #(.W(NUM_PORTS + 1), .INI({(NUM_PORTS + 1){1'b1}}))
  u_sync_pwr (
    .clk   (clk),
    .rst   (rst),
    .pin   ({shared_power_sense_pin_in | shared_power_sense_pin_oe,
             port_power_sense_pin_in | port_power_sense_pin_oe}),
    .level ({shared_pin_lvl, port_pin_lvl})
  );

  // Swap request and attach inputs idle low
  pprc_pin_sync #(.W(NUM_ATTACH + 1), .INI('0)) u_sync_ctl (
    .clk   (clk),
    .rst   (rst),
    .pin   ({role_swap_request, connector_attach}),
    .level ({swap_lvl, attach_lvl})
  );

  // ==========================================================================
  // Port power control
  // ==========================================================================
  // Port on only when config and host both allow it
  always_comb begin
    port_active = port_en_cfg & host_port_enable;
    any_active  = |port_active;
  end

  // One identical pin per port; held low in gang mode
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      port_power_sense_pin_out[i] = 1'b0;
      if (port_active[i] && !gang_mode) begin
        port_power_sense_pin_oe[i] = 1'b0;
        port_power_sense_pin_pu[i] = 1'b1;
      end else begin
        port_power_sense_pin_oe[i] = 1'b1;
        port_power_sense_pin_pu[i] = 1'b0;
      end
    end
  end

  // Shared pin powers every port in gang mode
  always_comb begin
    shared_power_sense_pin_out = 1'b0;
    if (gang_mode && any_active) begin
      shared_power_sense_pin_oe = 1'b0;
      shared_power_sense_pin_pu = 1'b1;
    end else begin
      shared_power_sense_pin_oe = 1'b1;
      shared_power_sense_pin_pu = 1'b0;
    end
  end

  // Overcurrent sensed as low level on an enabled port
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (gang_mode) begin
        oc_now[i] = port_active[i] && !shared_pin_lvl;
      end else begin
        oc_now[i] = port_active[i] && !port_pin_lvl[i];
      end
    end
  end

  // Registered overcurrent report to hub status logic
  always_ff @(posedge clk) begin
    if (rst) begin
      overcurrent_event <= '0;
    end else begin
      overcurrent_event <= oc_now;
    end
  end

  // ==========================================================================
  // Role swap and PHY power
  // ==========================================================================
  // Arrangement follows the synced request
  always_ff @(posedge clk) begin
    if (rst) begin
      role_swap_indicator <= 1'b0;
      port0_is_upstream   <= 1'b1;
      port1_is_upstream   <= 1'b0;
    end else begin
      role_swap_indicator <= swap_lvl;
      port0_is_upstream   <= !swap_lvl;
      port1_is_upstream   <= swap_lvl;
    end
  end

  // PHY power tracks attach; board may strap high
  always_ff @(posedge clk) begin
    if (rst) begin
      ss_phy_power_on <= '0;
    end else begin
      ss_phy_power_on <= attach_lvl;
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  // New overcurrent or arrangement change
  always_comb begin
    irq_set = {swap_lvl != role_swap_indicator, 2'h0,
               oc_now & ~overcurrent_event};
  end

  // Sticky status; set beats write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat <= '0;
    end else if (wr_fire && hit(aw_addr, OFF_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~w_data[8:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // Capture address and data in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Control registers; low byte lane carries all fields except irq_mask bit 8, which lane 1 carries
  always_ff @(posedge clk) begin
    if (rst) begin
      port_en_cfg <= RST_PORT_EN;
      gang_mode   <= RST_GANG;
      irq_mask    <= RST_IRQ_MASK;
    end else if (wr_fire) begin
      if (hit(aw_addr, OFF_PORT_EN) && w_strb[0]) begin
        port_en_cfg <= w_data[NUM_PORTS-1:0];
      end
      if (hit(aw_addr, OFF_CONFIG) && w_strb[0]) begin
        gang_mode <= w_data[CFG_GANG_BIT];
      end
      if (hit(aw_addr, OFF_IRQ_MASK)) begin
        if (w_strb[0]) irq_mask[7:0] <= w_data[7:0];
        if (w_strb[1]) irq_mask[8]   <= w_data[8];
      end
    end
  end

  // Write response after both halves
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr, OFF_PORT_EN) || hit(aw_addr, OFF_CONFIG) ||
          hit(aw_addr, OFF_IRQ_STAT) || hit(aw_addr, OFF_IRQ_MASK)) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  assign s_axi_arready = !s_axi_rvalid;

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rok   = 1'b1;
    if (hit(s_axi_araddr, OFF_PORT_EN)) begin
      next_rdata[NUM_PORTS-1:0] = port_en_cfg;
    end else if (hit(s_axi_araddr, OFF_CONFIG)) begin
      next_rdata[CFG_GANG_BIT] = gang_mode;
    end else if (hit(s_axi_araddr, OFF_STATE)) begin
      next_rdata[ST_OC_LSB +: NUM_PORTS]   = overcurrent_event;
      next_rdata[ST_ROLE_BIT]              = role_swap_indicator;
      next_rdata[ST_PHY_LSB +: NUM_ATTACH] = ss_phy_power_on;
    end else if (hit(s_axi_araddr, OFF_IRQ_STAT)) begin
      next_rdata[8:0] = irq_stat;
    end else if (hit(s_axi_araddr, OFF_IRQ_MASK)) begin
      next_rdata[8:0] = irq_mask;
    end else begin
      next_rok = 1'b0;
    end
  end

  // Read data held until taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: pprc_chk_sva.sv
`timescale 1ns/1ps
// ==================
// Pin behaviour checker
module pprc_chk
  import pprc_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Power pins
  input wire logic [NUM_PORTS-1:0]  port_power_sense_pin_in,
  input wire logic [NUM_PORTS-1:0]  port_power_sense_pin_out,
  input wire logic [NUM_PORTS-1:0]  port_power_sense_pin_oe,
  input wire logic [NUM_PORTS-1:0]  port_power_sense_pin_pu,
  input wire logic                  shared_power_sense_pin_oe,
  input wire logic [NUM_PORTS-1:0]  host_port_enable,
  // Role and attach
  input wire logic                  role_swap_request,
  input wire logic                  role_swap_indicator,
  input wire logic                  port0_is_upstream,
  input wire logic                  port1_is_upstream,
  input wire logic [NUM_ATTACH-1:0] connector_attach,
  input wire logic [NUM_ATTACH-1:0] ss_phy_power_on,
  // Events
  input wire logic [NUM_PORTS-1:0]  overcurrent_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_off_driven: assert property (
    (~host_port_enable & ~port_power_sense_pin_oe) == '0)
    else $error("host-off port pin not driven");
  chk_pullup_inv: assert property (
    port_power_sense_pin_pu == ~port_power_sense_pin_oe)
    else $error("pull-up not opposite of drive");
  chk_out_low: assert property (
    port_power_sense_pin_out == '0)
    else $error("pin data not low");
  chk_gang_pins: assert property (
    !shared_power_sense_pin_oe |-> &port_power_sense_pin_oe)
    else $error("per-port pin released in gang mode");
  chk_role_pair: assert property (
    port1_is_upstream == role_swap_indicator &&
    port0_is_upstream != port1_is_upstream)
    else $error("role outputs disagree");
  chk_role_follow: assert property (
    $stable(role_swap_request)[*8] |->
    role_swap_indicator == role_swap_request)
    else $error("arrangement does not follow request");
  chk_phy_follow: assert property (
    $changed(connector_attach) ##1 $stable(connector_attach)[*7]
    |=> ss_phy_power_on == connector_attach)
    else $error("phy power does not follow attach");
  chk_oc_quiet: assert property (
    (overcurrent_event & ~host_port_enable
     & ~$past(host_port_enable)) == '0)
    else $error("event on host-off port");
  chk_oc_report: assert property (
    (!port_power_sense_pin_in[0] && !port_power_sense_pin_oe[0]
     && host_port_enable[0])[*8] |-> overcurrent_event[0])
    else $error("low sense on active port not reported");
endmodule

bind pprc_top pprc_chk u_chk (
  .clk, .rst, .port_power_sense_pin_in, .port_power_sense_pin_out,
  .port_power_sense_pin_oe, .port_power_sense_pin_pu,
  .shared_power_sense_pin_oe, .host_port_enable, .role_swap_request,
  .role_swap_indicator, .port0_is_upstream, .port1_is_upstream,
  .connector_attach, .ss_phy_power_on, .overcurrent_event
);

// file: pprc_far.sv
`timescale 1ns/1ps
// ==================
// Power switches, current monitors, attach logic
module pprc_far
  import pprc_pkg::*;
(
  // Design side of the pins
  input wire logic [NUM_PORTS-1:0]  oe,
  input wire logic [NUM_PORTS-1:0]  pu,
  input wire logic [NUM_PORTS-1:0]  dout,
  input wire logic                  sh_oe,
  input wire logic                  sh_pu,
  input wire logic                  sh_out,
  // Fault and attach commands
  input wire logic [NUM_PORTS-1:0]  fault,
  input wire logic                  sh_fault,
  input wire logic [NUM_ATTACH-1:0] plug,
  // Wire levels
  output logic     [NUM_PORTS-1:0]  pin,
  output logic                      sh_pin,
  output logic     [NUM_ATTACH-1:0] attach,
  output logic     [NUM_PORTS-1:0]  pwr_on
);
  // Drive wins, then monitor pulls low, then pull-up
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      pin[i] = oe[i] ? dout[i] : (fault[i] ? 1'b0 : pu[i]);
    end
  end
  assign sh_pin = sh_oe ? sh_out : (sh_fault ? 1'b0 : sh_pu);
  // Switch conducts while its line is high
  assign pwr_on = pin;
  // Attach detector output, board may tie high
  assign attach = plug;
endmodule

// file: pprc_top_bench.sv
`timescale 1ns/1ps
// ==================
// Register-driven bench
module pprc_top_bench
  import pprc_pkg::*;
;
  // Stimulus
  logic                 clk = 1'b0, rst = 1'b1;
  logic [ADDR_W-1:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]          s_axi_wdata = 32'h0;
  logic [3:0]           s_axi_wstrb = 4'hF, plug = 4'h0;
  logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic                 s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic                 s_axi_rready = 1'b0, role_swap_request = 1'b0;
  logic [NUM_PORTS-1:0] host_port_enable = 6'h3F, fault = 6'h00;
  logic                 sh_fault = 1'b0;
  // Observed
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                 s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [31:0]          s_axi_rdata;
  logic [NUM_PORTS-1:0] port_power_sense_pin_in, port_power_sense_pin_out;
  logic [NUM_PORTS-1:0] port_power_sense_pin_oe, port_power_sense_pin_pu;
  logic [NUM_PORTS-1:0] overcurrent_event, pwr_on;
  logic                 shared_power_sense_pin_in, shared_power_sense_pin_out;
  logic                 shared_power_sense_pin_oe, shared_power_sense_pin_pu;
  logic                 role_swap_indicator, port0_is_upstream;
  logic                 port1_is_upstream;
  logic [3:0]           connector_attach, ss_phy_power_on;
  logic [3:0]           pats [4] = '{4'h0, 4'h9, 4'h6, 4'hF};
  int                   err_total = 0, num_checks = 0;

  always #50 clk = ~clk;

  pprc_top DUT (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_power_sense_pin_in,
    .port_power_sense_pin_out, .port_power_sense_pin_oe,
    .port_power_sense_pin_pu, .shared_power_sense_pin_in,
    .shared_power_sense_pin_out, .shared_power_sense_pin_oe,
    .shared_power_sense_pin_pu, .host_port_enable, .role_swap_request,
    .role_swap_indicator, .port0_is_upstream, .port1_is_upstream,
    .connector_attach, .ss_phy_power_on, .overcurrent_event, .irq
  );

  pprc_far far (
    .oe(port_power_sense_pin_oe), .pu(port_power_sense_pin_pu),
    .dout(port_power_sense_pin_out), .sh_oe(shared_power_sense_pin_oe),
    .sh_pu(shared_power_sense_pin_pu), .sh_out(shared_power_sense_pin_out),
    .fault, .sh_fault, .plug, .pin(port_power_sense_pin_in),
    .sh_pin(shared_power_sense_pin_in), .attach(connector_attach), .pwr_on
  );

  // Compare and count
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Write, each channel released on its own handshake
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, er);
  endtask

  // Read, data compared only on a normal answer
  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp,
          input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    check("rresp", s_axi_rresp, er);
    if (er === RESP_OKAY) check(nm, s_axi_rdata, exp);
  endtask

  // Verdict and end of run
  task results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end

  // ==================
  // Test sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("oe", port_power_sense_pin_oe, 6'h3F);
    check("ind", role_swap_indicator, 1'b0);
    check("up0", port0_is_upstream, 1'b1);
    check("phy", ss_phy_power_on, 4'h0);
    check("irq", irq, 1'b0);
    rd("en", OFF_PORT_EN, 32'h0, RESP_OKAY);
    rd("cfg", OFF_CONFIG, 32'h0, RESP_OKAY);
    rd("mask", OFF_IRQ_MASK, 32'h0, RESP_OKAY);
    rd("hole", 8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    // Per-port release, then host disable
    wr(OFF_PORT_EN, 32'h2A, RESP_OKAY);
    @(posedge clk);
    check("oe", port_power_sense_pin_oe, 6'h15);
    check("pu", port_power_sense_pin_pu, 6'h2A);
    check("pwr", pwr_on, 6'h2A);
    host_port_enable <= 6'h0A;
    @(posedge clk);
    check("oe", port_power_sense_pin_oe, 6'h35);
    host_port_enable <= 6'h3F;
    wr(OFF_PORT_EN, 32'h3D, RESP_OKAY);
    // Fault on active and inactive port
    fault <= 6'h03;
    repeat (10) @(posedge clk);
    check("oc", overcurrent_event, 6'h01);
    rd("stat", OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    check("irq", irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    check("irq", irq, 1'b1);
    fault <= 6'h00;
    repeat (10) @(posedge clk);
    check("oc", overcurrent_event, 6'h00);
    wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    check("irq", irq, 1'b0);
    rd("stat", OFF_IRQ_STAT, 32'h0, RESP_OKAY);
    // Gang mode
    wr(OFF_CONFIG, 32'h1, RESP_OKAY);
    @(posedge clk);
    check("oe", port_power_sense_pin_oe, 6'h3F);
    check("shoe", shared_power_sense_pin_oe, 1'b0);
    check("shpu", shared_power_sense_pin_pu, 1'b1);
    check("shout", shared_power_sense_pin_out, 1'b0);
    sh_fault <= 1'b1;
    repeat (10) @(posedge clk);
    check("oc", overcurrent_event, 6'h3D);
    sh_fault <= 1'b0;
    wr(OFF_CONFIG, 32'h0, RESP_OKAY);
    repeat (10) @(posedge clk);
    wr(OFF_IRQ_STAT, 32'h13F, RESP_OKAY);
    // Role swap with its event unmasked
    wr(OFF_IRQ_MASK, 32'h100, RESP_OKAY);
    for (int i = 1; i >= 0; i--) begin
      role_swap_request <= i[0];
      repeat (10) @(posedge clk);
      check("ind", role_swap_indicator, i[0]);
      check("up0", port0_is_upstream, !i[0]);
      check("up1", port1_is_upstream, i[0]);
      check("irq", irq, 1'b1);
      wr(OFF_IRQ_STAT, 32'h100, RESP_OKAY);
      repeat (2) @(posedge clk);
      check("irq", irq, 1'b0);
    end
    // Attach patterns, all-high tie last
    for (int k = 0; k < 4; k++) begin
      plug <= pats[k];
      repeat (10) @(posedge clk);
      check("phy", ss_phy_power_on, pats[k]);
    end
    results();
  end
endmodule
